// File: logic/seep_map.svh
`ifndef SEEP_MAP_SVH
`define SEEP_MAP_SVH

// Fixed upper nibble of the device address word.
`define SEEP_DEV_TYPE      4'hA
`define SEEP_CLK_HZ        50000000
// Longest internal write cycle, in milliseconds.
`define SEEP_T_WR_MS       5
`define SEEP_WR_CYCLES     (`SEEP_T_WR_MS * (`SEEP_CLK_HZ / 1000))
`define SEEP_WCNT_W        18
`define SEEP_AW            11
`define SEEP_DEPTH         2048
`define SEEP_LATCH_N       16
`define SEEP_FIFO_DEPTH    4
`define SEEP_FIFO_W        19
`define SEEP_BIT_ACK       4'h8
`define SEEP_AMASK_2K      11'h0FF
`define SEEP_AMASK_4K      11'h1FF
`define SEEP_AMASK_8K      11'h3FF
`define SEEP_AMASK_16K     11'h7FF
`define SEEP_PMASK_SMALL   11'h007
`define SEEP_PMASK_LARGE   11'h00F
`define SEEP_CMASK_2K      3'h7
`define SEEP_CMASK_4K      3'h6
`define SEEP_CMASK_8K      3'h4
`define SEEP_CMASK_16K     3'h0

`endif

// File: logic/seep_pkg.sv
`default_nettype none

package seep_pkg;

  typedef enum logic [1:0] {SEEP_D2K, SEEP_D4K, SEEP_D8K, SEEP_D16K} seep_density_t;

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADR, ST_WDAT, ST_RDAT, ST_RACK} seep_state_t;

  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [2:0]  cs_m;
    logic [2:0]  cs_s;
    logic        wp_m;
    logic        wp_s;
    seep_state_t st;
    logic [3:0]  cnt;
    logic        in_ack;
    logic        acked;
    logic [7:0]  sh;
    logic [7:0]  dev;
    logic [10:0] addr;
    logic        wr_pend;
    logic        busy;
    logic        commit_sent;
    logic [17:0] wcnt;
    logic        sda_oe;
  } seep_top_t;

  typedef struct packed {
    logic [7:0]  rd_data;
    logic        committing;
    logic [3:0]  idx;
    logic [6:0]  page;
    logic [15:0] valid;
  } seep_mem_t;

endpackage : seep_pkg
`default_nettype wire

// File: logic/seep_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "seep_map.svh"

module seep_fifo #(
  parameter int W = `SEEP_FIFO_W,
  parameter int D = `SEEP_FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wptr;
    logic [PW-1:0]       rptr;
    logic [PW:0]         cnt;
  } seep_fifo_st_t;

  seep_fifo_st_t r_reg;
  seep_fifo_st_t r_next;
  logic          push;
  logic          pop;

  assign in_ready_o  = (r_reg.cnt != (PW+1)'(D));
  assign out_valid_o = (r_reg.cnt != '0);
  assign out_data_o  = r_reg.mem[r_reg.rptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wptr] = in_data_i;
      r_next.wptr            = r_reg.wptr + 1'b1;
    end
    if (pop) begin
      r_next.rptr = r_reg.rptr + 1'b1;
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

endmodule : seep_fifo
`default_nettype wire

// File: logic/seep_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "seep_map.svh"

module seep_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [10:0] rd_addr_i,
  output logic [7:0]       rd_data_o,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [10:0] wr_addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        commit_i,
  output logic             committing_o
);
  // The cell array keeps no reset, as nonvolatile storage would not.
  logic [7:0]        arr_mem [`SEEP_DEPTH];
  logic [7:0]        latch_mem [`SEEP_LATCH_N];
  seep_pkg::seep_mem_t r_reg;
  seep_pkg::seep_mem_t r_next;

  assign rd_data_o    = r_reg.rd_data;
  assign committing_o = r_reg.committing;
  assign wr_ready_o   = !r_reg.committing && !commit_i;

  always_comb begin
    r_next         = r_reg;
    r_next.rd_data = arr_mem[rd_addr_i];
    if (r_reg.committing) begin
      r_next.valid[r_reg.idx] = 1'b0;
      r_next.idx              = r_reg.idx + 4'h1;
      if (r_reg.idx == 4'hF) begin
        r_next.committing = 1'b0;
      end
    end else if (commit_i) begin
      r_next.committing = 1'b1;
      r_next.idx        = 4'h0;
    end else if (wr_valid_i) begin
      r_next.valid[wr_addr_i[3:0]] = 1'b1;
      r_next.page                  = wr_addr_i[10:4];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Bytes wait in the page latch until the stop, so an aborted frame leaves cells alone.
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_valid_i && wr_ready_o) begin
      latch_mem[wr_addr_i[3:0]] <= wr_data_i;
    end
    if (ce_i && r_reg.committing && r_reg.valid[r_reg.idx]) begin
      arr_mem[{r_reg.page, r_reg.idx}] <= latch_mem[r_reg.idx];
    end
  end

endmodule : seep_mem
`default_nettype wire

// File: logic/seep_target.sv
`timescale 1ns/10ps
`default_nettype none
`include "seep_map.svh"

module seep_target #(
  parameter seep_pkg::seep_density_t DENSITY   = seep_pkg::SEEP_D16K,
  parameter int                      WR_CYCLES = `SEEP_WR_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic chip_select_bit_zero_i,
  input  wire logic chip_select_bit_one_i,
  input  wire logic chip_select_bit_two_i,
  input  wire logic write_protect_i,
  output logic      write_busy_o
);
  localparam logic [10:0] AMASK = (DENSITY == seep_pkg::SEEP_D2K) ? `SEEP_AMASK_2K :
                                  (DENSITY == seep_pkg::SEEP_D4K) ? `SEEP_AMASK_4K :
                                  (DENSITY == seep_pkg::SEEP_D8K) ? `SEEP_AMASK_8K : `SEEP_AMASK_16K;
  localparam logic [10:0] PMASK = (DENSITY == seep_pkg::SEEP_D2K) ? `SEEP_PMASK_SMALL : `SEEP_PMASK_LARGE;
  localparam logic [2:0]  CMASK = (DENSITY == seep_pkg::SEEP_D2K) ? `SEEP_CMASK_2K :
                                  (DENSITY == seep_pkg::SEEP_D4K) ? `SEEP_CMASK_4K :
                                  (DENSITY == seep_pkg::SEEP_D8K) ? `SEEP_CMASK_8K : `SEEP_CMASK_16K;
  localparam logic [17:0] WR_LAST = 18'(WR_CYCLES - 1);

  seep_pkg::seep_top_t r_reg;
  seep_pkg::seep_top_t r_next;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        ack_go;
  logic        fifo_push;
  logic        fifo_ready;
  logic        fifo_out_valid;
  logic [18:0] fifo_out_data;
  logic        mem_wr_ready;
  logic        mem_commit;
  logic [7:0]  rd_data;
  logic        rd_load;
  logic        dev_ok;

  // Edges are taken between the second sync stage and a third copy.
  assign scl_rise  = r_reg.scl_s[1] && !r_reg.scl_s[2];
  assign scl_fall  = !r_reg.scl_s[1] && r_reg.scl_s[2];
  assign start_det = r_reg.scl_s[1] && r_reg.scl_s[2] && !r_reg.sda_s[1] && r_reg.sda_s[2];
  assign stop_det  = r_reg.scl_s[1] && r_reg.scl_s[2] && r_reg.sda_s[1] && !r_reg.sda_s[2];
  assign dev_ok    = (r_reg.sh[7:4] == `SEEP_DEV_TYPE) && ((r_reg.sh[3:1] & CMASK) == (r_reg.cs_s & CMASK));

  assign sda_o        = 1'b0;
  assign sda_oe_o     = r_reg.sda_oe;
  assign write_busy_o = r_reg.busy;

  always_comb begin
    r_next     = r_reg;
    ack_go     = 1'b0;
    fifo_push  = 1'b0;
    mem_commit = 1'b0;
    rd_load    = 1'b0;
    r_next.scl_s = {r_reg.scl_s[1:0], scl_i};
    r_next.sda_s = {r_reg.sda_s[1:0], sda_i};
    r_next.cs_m  = {chip_select_bit_two_i, chip_select_bit_one_i, chip_select_bit_zero_i};
    r_next.cs_s  = r_reg.cs_m;
    r_next.wp_m  = write_protect_i;
    r_next.wp_s  = r_reg.wp_m;
    if (r_reg.busy) begin
      // The bus is deaf here, so polls see no acknowledge.
      r_next.st     = seep_pkg::ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.in_ack = 1'b0;
      if (r_reg.wcnt == WR_LAST) begin
        r_next.busy = 1'b0;
      end else begin
        r_next.wcnt = r_reg.wcnt + 18'h00001;
      end
      if (!r_reg.commit_sent && !fifo_out_valid) begin
        mem_commit         = 1'b1;
        r_next.commit_sent = 1'b1;
      end
    end else if (stop_det) begin
      r_next.st     = seep_pkg::ST_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.in_ack = 1'b0;
      if (r_reg.wr_pend) begin
        r_next.busy        = 1'b1;
        r_next.wcnt        = 18'h00000;
        r_next.commit_sent = 1'b0;
        r_next.wr_pend     = 1'b0;
      end
    end else if (start_det) begin
      // A repeated start after a dummy write keeps the loaded address.
      r_next.st     = seep_pkg::ST_DEV;
      r_next.cnt    = 4'h0;
      r_next.in_ack = 1'b0;
      r_next.sda_oe = 1'b0;
    end else begin
      unique case (r_reg.st)
        seep_pkg::ST_IDLE: begin
        end
        seep_pkg::ST_DEV, seep_pkg::ST_WADR, seep_pkg::ST_WDAT: begin
          if (scl_rise && r_reg.cnt != `SEEP_BIT_ACK) begin
            r_next.sh  = {r_reg.sh[6:0], r_reg.sda_s[1]};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (scl_fall && r_reg.cnt == `SEEP_BIT_ACK && !r_reg.in_ack) begin
            if (r_reg.st == seep_pkg::ST_DEV) begin
              if (dev_ok) begin
                r_next.dev = r_reg.sh;
                ack_go     = 1'b1;
              end else begin
                r_next.st = seep_pkg::ST_IDLE;
              end
            end else if (r_reg.st == seep_pkg::ST_WADR) begin
              r_next.addr = {r_reg.dev[3:1] & ~CMASK, r_reg.sh} & AMASK;
              ack_go      = 1'b1;
            end else if (r_reg.wp_s || fifo_ready) begin
              // Protected bytes are still acknowledged but never reach the latch.
              ack_go         = 1'b1;
              fifo_push      = !r_reg.wp_s;
              r_next.wr_pend = r_reg.wr_pend || !r_reg.wp_s;
              r_next.addr    = (r_reg.addr & ~PMASK) | ((r_reg.addr + 11'h001) & PMASK);
            end else begin
              // A full buffer drops the byte with no acknowledge.
              r_next.st = seep_pkg::ST_IDLE;
            end
            if (ack_go) begin
              r_next.sda_oe = 1'b1;
              r_next.in_ack = 1'b1;
            end
          end else if (scl_fall && r_reg.in_ack) begin
            r_next.sda_oe = 1'b0;
            r_next.in_ack = 1'b0;
            r_next.cnt    = 4'h0;
            if (r_reg.st == seep_pkg::ST_DEV && r_reg.dev[0]) begin
              r_next.st     = seep_pkg::ST_RDAT;
              r_next.sh     = rd_data;
              r_next.sda_oe = !rd_data[7];
              r_next.addr   = (r_reg.addr + 11'h001) & AMASK;
              rd_load       = 1'b1;
            end else if (r_reg.st == seep_pkg::ST_DEV) begin
              r_next.st = seep_pkg::ST_WADR;
            end else begin
              r_next.st = seep_pkg::ST_WDAT;
            end
          end
        end
        seep_pkg::ST_RDAT: begin
          if (scl_rise) begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (scl_fall && r_reg.cnt == `SEEP_BIT_ACK) begin
            r_next.sda_oe = 1'b0;
            r_next.acked  = 1'b0;
            r_next.st     = seep_pkg::ST_RACK;
          end else if (scl_fall) begin
            r_next.sh     = {r_reg.sh[6:0], 1'b0};
            r_next.sda_oe = !r_reg.sh[6];
          end
        end
        seep_pkg::ST_RACK: begin
          if (scl_rise) begin
            r_next.acked = !r_reg.sda_s[1];
          end else if (scl_fall && r_reg.acked) begin
            r_next.st     = seep_pkg::ST_RDAT;
            r_next.cnt    = 4'h0;
            r_next.sh     = rd_data;
            r_next.sda_oe = !rd_data[7];
            r_next.addr   = (r_reg.addr + 11'h001) & AMASK;
            rd_load       = 1'b1;
          end else if (scl_fall) begin
            r_next.st = seep_pkg::ST_IDLE;
          end
        end
        default: begin
          r_next.st = seep_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // The address survives stops and starts; only reset clears it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  seep_fifo #(
    .W (`SEEP_FIFO_W),
    .D (`SEEP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({r_reg.addr, r_reg.sh}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (mem_wr_ready),
    .out_data_o  (fifo_out_data)
  );

  seep_mem u_mem (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .rd_addr_i    (r_reg.addr),
    .rd_data_o    (rd_data),
    .wr_valid_i   (fifo_out_valid),
    .wr_ready_o   (mem_wr_ready),
    .wr_addr_i    (fifo_out_data[18:8]),
    .wr_data_i    (fifo_out_data[7:0]),
    .commit_i     (mem_commit),
    .committing_o ()
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_ack_hold;
    sda_oe_o [*3];
  endsequence

  sequence s_read_entry;
    scl_fall && r_reg.in_ack && (r_reg.st == seep_pkg::ST_DEV) && r_reg.dev[0] && !r_reg.busy && !stop_det && !start_det;
  endsequence

  // Start, stop and the write cycle win over bit handling, so the steps below leave those cycles out.
  sequence s_addr_taken;
    scl_fall && (r_reg.cnt == `SEEP_BIT_ACK) && !r_reg.in_ack && (r_reg.st == seep_pkg::ST_WADR) &&
    !r_reg.busy && !stop_det && !start_det;
  endsequence

  sequence s_ack_end;
    scl_fall && r_reg.in_ack && !r_reg.busy && !stop_det && !start_det &&
    !((r_reg.st == seep_pkg::ST_DEV) && r_reg.dev[0]);
  endsequence

  sequence s_read_nack;
    scl_fall && (r_reg.st == seep_pkg::ST_RACK) && !r_reg.acked && !r_reg.busy && !stop_det && !start_det;
  endsequence

  ack_low_a: assert property (ack_go |=> s_ack_hold)
    else $error("acknowledge not held low");
  busy_quiet_a: assert property (write_busy_o |-> !sda_oe_o)
    else $error("data line driven during write cycle");
  stop_commit_a: assert property ((stop_det && r_reg.wr_pend && !r_reg.busy) |=> write_busy_o)
    else $error("stop did not start write cycle");
  protect_push_a: assert property (fifo_push |-> !r_reg.wp_s)
    else $error("byte stored while protected");
  page_keep_a: assert property (fifo_push |=> ((r_reg.addr & ~PMASK) == ($past(r_reg.addr) & ~PMASK)))
    else $error("write address left its page");
  read_step_a: assert property (rd_load |=> (r_reg.addr == (($past(r_reg.addr) + 11'h001) & AMASK)))
    else $error("read address step wrong");
  line_release_a: assert property ((r_reg.st == seep_pkg::ST_IDLE || r_reg.st == seep_pkg::ST_RACK) |-> !sda_oe_o)
    else $error("data line not released");
  write_time_a: assert property ($rose(write_busy_o) |-> (r_reg.wcnt == 18'h00000) ##1 (r_reg.wcnt <= WR_LAST))
    else $error("write cycle timer wrong");
  poll_nack_a: assert property (r_reg.busy |-> !ack_go)
    else $error("acknowledge during write cycle");
  read_entry_a: assert property (s_read_entry |=> (r_reg.st == seep_pkg::ST_RDAT) && (sda_oe_o == !$past(rd_data[7])))
    else $error("read did not start after address");
  addr_load_a: assert property (s_addr_taken |=> (r_reg.addr[7:0] == $past(r_reg.sh)))
    else $error("word address not loaded");
  page_bits_a: assert property (s_addr_taken |=>
                                (r_reg.addr[10:8] == ($past(r_reg.dev[3:1]) & ~CMASK & AMASK[10:8])))
    else $error("page select bits not applied");
  page_step_a: assert property (fifo_push |=>
                                ((r_reg.addr & PMASK) == (($past(r_reg.addr) + 11'h001) & PMASK)))
    else $error("in-page address step wrong");
  ack_end_a: assert property (s_ack_end |=> !sda_oe_o)
    else $error("acknowledge not released after ninth clock");
  read_stop_a: assert property (s_read_nack |=> (r_reg.st == seep_pkg::ST_IDLE) && !sda_oe_o)
    else $error("read not ended after missing acknowledge");
  write_end_a: assert property ((write_busy_o && (r_reg.wcnt == WR_LAST)) |=> !write_busy_o)
    else $error("write cycle overran its count");
  protect_idle_a: assert property ((stop_det && !r_reg.wr_pend && !r_reg.busy) |=> !write_busy_o)
    else $error("write cycle started with nothing stored");

endmodule : seep_target
`default_nettype wire

// File: verif/seep_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module seep_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_pull_o
);

  // The bus clock stands high between frames and the data line is left to its pull-up.
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic clk_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : clk_n

  // Serves as a first start and as a repeated start alike.
  task automatic start();
    sda_pull_o = 1'b0;
    clk_n(3);
    scl_o = 1'b1;
    clk_n(4);
    sda_pull_o = 1'b1;
    clk_n(4);
    scl_o = 1'b0;
    clk_n(1);
  endtask : start

  // Data moves one system clock after the fall, so the synchronisers never see it race the clock.
  task automatic bit_x(input logic b, output logic r);
    sda_pull_o = ~b;
    clk_n(3);
    scl_o = 1'b1;
    clk_n(4);
    r     = sda_i;
    scl_o = 1'b0;
    clk_n(1);
  endtask : bit_x

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : send

  // The ninth bit is driven low to ask for more, released to end the read.
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~more, r);
  endtask : recv

  task automatic stop();
    sda_pull_o = 1'b1;
    clk_n(3);
    scl_o = 1'b1;
    clk_n(4);
    sda_pull_o = 1'b0;
    clk_n(4);
  endtask : stop

endmodule : seep_master_model

`default_nettype wire

// File: verif/test_seep_target.sv
`timescale 1ns/10ps
`default_nettype none
`include "seep_map.svh"

module test_seep_target;

  localparam int WR_T     = 200;
  // The tests need about 4800 system clocks; the limit of 50000 leaves a wide margin.
  localparam int WATCH_NS = 1000000;

  logic clk_i           = 1'b0;
  logic rst_i           = 1'b1;
  logic write_protect_i = 1'b0;
  logic scl;
  logic m_pull;
  logic d_oe;
  logic d_sda;
  logic busy;
  wire  sda_bus;
  int   err_count       = 0;
  int   checked         = 0;

  // Open-drain line with a pull-up: low whenever either side pulls.
  assign sda_bus = (d_oe ? d_sda : 1'b1) & ~m_pull;

  always #10 clk_i = ~clk_i;

  seep_target #(
    .DENSITY   (seep_pkg::SEEP_D16K),
    .WR_CYCLES (WR_T)
  ) seep_target_inst (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .ce_i                   (1'b1),
    .scl_i                  (scl),
    .sda_i                  (sda_bus),
    .sda_o                  (d_sda),
    .sda_oe_o               (d_oe),
    .chip_select_bit_zero_i (1'b0),
    .chip_select_bit_one_i  (1'b0),
    .chip_select_bit_two_i  (1'b0),
    .write_protect_i        (write_protect_i),
    .write_busy_o           (busy)
  );

  seep_master_model seep_master_model_inst (
    .clk_i      (clk_i),
    .sda_i      (sda_bus),
    .scl_o      (scl),
    .sda_pull_o (m_pull)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic open_at(input logic [10:0] a);
    logic ack;
    seep_master_model_inst.start();
    seep_master_model_inst.send({`SEEP_DEV_TYPE, a[10:8], 1'b0}, ack);
    chk1(ack, 1'b1);
    seep_master_model_inst.send(a[7:0], ack);
    chk1(ack, 1'b1);
  endtask : open_at

  task automatic write_seq(input logic [10:0] a, input logic [7:0] d[$]);
    logic ack;
    open_at(a);
    foreach (d[i]) begin
      seep_master_model_inst.send(d[i], ack);
      chk1(ack, 1'b1);
    end
    seep_master_model_inst.stop();
  endtask : write_seq

  task automatic read_seq(input logic rnd, input logic [10:0] a, input logic [7:0] e[$]);
    logic       ack;
    logic [7:0] d;
    if (rnd) open_at(a);
    seep_master_model_inst.start();
    seep_master_model_inst.send({`SEEP_DEV_TYPE, a[10:8], 1'b1}, ack);
    chk1(ack, 1'b1);
    foreach (e[i]) begin
      seep_master_model_inst.recv(i < e.size() - 1, d);
      chk8(d, e[i]);
    end
    seep_master_model_inst.stop();
    tick(6);
    chk1(d_oe, 1'b0);
  endtask : read_seq

  task automatic wait_done();
    int n;
    n = 0;
    tick(4);
    while (busy === 1'b1 && n < WR_T + 8) begin
      tick(1);
      n++;
    end
    chk1(busy, 1'b0);
  endtask : wait_done

  task automatic t_byte_write();
    logic ack;
    write_seq(11'h123, '{8'h5A});
    tick(4);
    chk1(busy, 1'b1);
    seep_master_model_inst.start();
    seep_master_model_inst.send({`SEEP_DEV_TYPE, 3'h1, 1'b0}, ack);
    chk1(ack, 1'b0);
    seep_master_model_inst.stop();
    wait_done();
    read_seq(1'b1, 11'h123, '{8'h5A});
    $display("Test byte_write done");
  endtask : t_byte_write

  task automatic t_page_wrap();
    logic [7:0] w[$];
    logic [7:0] e[$];
    write_seq(11'h000, '{8'hC3});
    wait_done();
    for (int i = 0; i < 18; i++) begin
      w.push_back(8'h30 + 8'(i));
    end
    write_seq(11'h7FE, w);
    wait_done();
    for (int s = 0; s < 16; s++) begin
      e.push_back(s >= 14 ? 8'h40 + 8'(s - 14) : 8'h32 + 8'(s));
    end
    e.push_back(8'hC3);
    read_seq(1'b0, 11'h7F0, e);
    $display("Test page_wrap done");
  endtask : t_page_wrap

  task automatic t_protect();
    write_protect_i = 1'b1;
    tick(4);
    write_seq(11'h123, '{8'hEE});
    tick(8);
    chk1(busy, 1'b0);
    write_protect_i = 1'b0;
    tick(4);
    read_seq(1'b1, 11'h123, '{8'h5A});
    $display("Test protect done");
  endtask : t_protect

  task automatic print_verdict();
    $display("Counts: %0d checked, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    tick(6);
    rst_i = 1'b0;
    tick(6);
    t_byte_write();
    t_page_wrap();
    t_protect();
    print_verdict();
  end

  initial begin
    #(WATCH_NS);
    err_count++;
    print_verdict();
  end

endmodule : test_seep_target

`default_nettype wire
